/* File: hdl/gdt_pin_det.sv */
// one pin: three-stage synchroniser and edge or level detection
// assumes pad_in is asynchronous to clk
`timescale 1ns/1ps
module gdt_pin_det
(
  input  wire logic clk,
  input  wire logic rst_n,
  gdt_pin_if.det    pin
);

  typedef struct packed
  {
    logic [2:0] sync;
    logic       stable;
  } gdt_det_type;

  gdt_det_type st_reg;
  gdt_det_type st_next;
  logic        new_level;

  always_comb
  begin
    st_next      = st_reg;
    st_next.sync = {st_reg.sync[1:0], pin.pad_in};
    // stage 0 is read only by stage 1; stages 1 and 2 must agree
    new_level    = st_reg.stable;
    if (st_reg.sync[1] == st_reg.sync[2])
    begin
      new_level = st_reg.sync[2];
    end
    st_next.stable = new_level;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '{sync: gdt_pkg::SYNC_RESET, stable: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  always_comb
  begin
    pin.level     = st_reg.stable;
    pin.edge_hit  = 1'b0;
    pin.level_hit = 1'b0;
    case (pin.sense)
      gdt_pkg::SENSE_FALL: pin.edge_hit  = st_reg.stable & ~new_level;
      gdt_pkg::SENSE_RISE: pin.edge_hit  = ~st_reg.stable & new_level;
      gdt_pkg::SENSE_BOTH: pin.edge_hit  = st_reg.stable ^ new_level;
      gdt_pkg::SENSE_LOW:  pin.level_hit = ~st_reg.stable;
      gdt_pkg::SENSE_HIGH: pin.level_hit = st_reg.stable;
      default:             pin.level_hit = 1'b0;
    endcase
  end

endmodule : gdt_pin_det

/* File: hdl/gdt_pin_if.sv */
// per-pin bundle between the port top and a pin detector slice
// assumes one system clock shared by both ends
`timescale 1ns/1ps
interface gdt_pin_if;
  logic       pad_in;
  logic [2:0] sense;
  logic       level;
  logic       edge_hit;
  logic       level_hit;

  modport det
  (
    input  pad_in,
    input  sense,
    output level,
    output edge_hit,
    output level_hit
  );
  modport top
  (
    output pad_in,
    output sense,
    input  level,
    input  edge_hit,
    input  level_hit
  );
endinterface : gdt_pin_if

/* File: hdl/gdt_pkg.sv */
// constants, field layouts and encodings of the eight-pin gpio port block
// assumes a 32-bit avalon-mm slave whose top decodes these byte offsets directly
package gdt_pkg;

  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned ADDR_W    = 6;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] DIR_SET_OFS  = 6'h00;
  localparam logic [5:0] DIR_GET_OFS  = 6'h04;
  localparam logic [5:0] PAD_EN_OFS   = 6'h08;
  localparam logic [5:0] DMA_SET_OFS  = 6'h0C;
  localparam logic [5:0] DMA_CLR_OFS  = 6'h10;
  localparam logic [5:0] INT_EN_OFS   = 6'h14;
  localparam logic [5:0] INT_DIS_OFS  = 6'h18;
  localparam logic [5:0] INT_STAT_OFS = 6'h1C;
  localparam logic [5:0] INT_CLR_OFS  = 6'h20;
  localparam logic [5:0] TYPE_SET_OFS = 6'h24;
  localparam logic [5:0] TYPE_GET_OFS = 6'h28;
  localparam logic [5:0] DATA_OUT_OFS = 6'h2C;
  localparam logic [5:0] PIN_IN_OFS   = 6'h30;
  localparam logic [5:0] DMA_ACT_OFS  = 6'h34;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned MASK_LSB    = 0;
  localparam int unsigned VALUE_LSB   = 8;
  localparam int unsigned SEL_LSB     = 16;
  localparam int unsigned DISC_BIT    = 3;
  localparam int unsigned VIEW_BIT    = 31;
  localparam int unsigned DMA_SRC_BIT = 8;

  // ---------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] DIR_IN      = 2'h0;
  localparam logic [1:0] DIR_OUT     = 2'h1;
  localparam logic [1:0] DIR_HW      = 2'h2;
  localparam logic [2:0] SENSE_FALL  = 3'h0;
  localparam logic [2:0] SENSE_RISE  = 3'h1;
  localparam logic [2:0] SENSE_BOTH  = 3'h2;
  localparam logic [2:0] SENSE_LOW   = 3'h3;
  localparam logic [2:0] SENSE_HIGH  = 3'h4;
  localparam logic [1:0] DIR_RESET   = 2'h0;
  localparam logic [2:0] SENSE_RESET = 3'h0;
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic [8:0] FLAG_RESET  = 9'h000;
  localparam logic [2:0] SYNC_RESET  = 3'h0;
  localparam int unsigned WAIT_CYCLES = 1;

endpackage : gdt_pkg

/* File: hdl/gdt_port.sv */
// eight-pin gpio port: direction, pad gating, dma trigger and interrupts
// assumes an avalon-mm master on SYS_CLK and asynchronous pad inputs
//
// What this block does
// - each configuration write uses an 8-bit pin mask; only masked pins change.
// - each pin is software input, software output or hardware controlled.
// - any single pin's direction setting reads back as its encoded value.
// - a pad is driven and reaches HW_IN only when its pad enable is set; detection and pin readback see it ungated.
// - any pin can be enabled as a dma start trigger.
// - clearing a pin's trigger enable stops only that pin's triggers.
// - a trigger pin still raises its interrupt when that is enabled.
// - nine interrupt sources: pins 0 to 7 and port dma activity.
// - only enabled sources drive the port interrupt output.
// - a clear write clears exactly the named edge and dma pending flags; level flags ignore it.
// - status reads as raw or masked view.
// - detection is falling, rising, both edges, low or high level.
// - a discrete option gives a pin its own interrupt output.
// - type readback returns the sense and the discrete option.
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module gdt_port
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic [7:0]  PAD_IN,
  output logic      [7:0]  PAD_OUT,
  output logic      [7:0]  PAD_OE,
  input  wire logic [7:0]  HW_OUT,
  input  wire logic [7:0]  HW_OE,
  output logic      [7:0]  HW_IN,
  input  wire logic        DMA_DONE,
  output logic      [7:0]  DMA_REQ,
  output logic             PORT_IRQ,
  output logic      [7:0]  PIN_IRQ
);

  localparam int unsigned N = gdt_pkg::PIN_COUNT;

  typedef struct packed
  {
    logic [N-1:0][1:0] dir;
    logic [N-1:0][2:0] sense;
    logic [N-1:0]      discrete;
    logic [N-1:0]      pad_en;
    logic [N-1:0]      dma_en;
    logic [N-1:0]      data_out;
    logic [8:0]        raw;
    logic [8:0]        int_en;
    logic [7:0]        sel_dir;
    logic [7:0]        sel_type;
    logic              view;
    logic              acked;
    logic              waitreq;
    logic [31:0]       rdata;
    logic [7:0]        pad_out;
    logic [7:0]        pad_oe;
    logic [7:0]        hw_in;
    logic [7:0]        dma_req;
    logic              port_irq;
    logic [7:0]        pin_irq;
  } gdt_state_type;

  // field reset values come from the package, single bits and rdata are literals; only waitrequest idles high
  localparam gdt_state_type ST_RESET = '{
    dir:      {N{gdt_pkg::DIR_RESET}},
    sense:    {N{gdt_pkg::SENSE_RESET}},
    discrete: gdt_pkg::BYTE_RESET,
    pad_en:   gdt_pkg::BYTE_RESET,
    dma_en:   gdt_pkg::BYTE_RESET,
    data_out: gdt_pkg::BYTE_RESET,
    raw:      gdt_pkg::FLAG_RESET,
    int_en:   gdt_pkg::FLAG_RESET,
    sel_dir:  gdt_pkg::BYTE_RESET,
    sel_type: gdt_pkg::BYTE_RESET,
    view:     1'b0,
    acked:    1'b0,
    waitreq:  1'b1,
    rdata:    32'h00000000,
    pad_out:  gdt_pkg::BYTE_RESET,
    pad_oe:   gdt_pkg::BYTE_RESET,
    hw_in:    gdt_pkg::BYTE_RESET,
    dma_req:  gdt_pkg::BYTE_RESET,
    port_irq: 1'b0,
    pin_irq:  gdt_pkg::BYTE_RESET
  };

  gdt_state_type st_reg;
  gdt_state_type st_next;

  logic [N-1:0] level;
  logic [N-1:0] edge_hit;
  logic [N-1:0] level_hit;
  logic [N-1:0] pad_gated;

  // ---------------------------------------------------------------
  // per-pin detectors
  // ---------------------------------------------------------------
  // the detectors see the pad ungated: pad enable only gates what leaves the port
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_pin
      gdt_pin_if pif ();
      assign pif.pad_in   = PAD_IN[g];
      assign pif.sense    = st_reg.sense[g];
      assign level[g]     = pif.level;
      assign edge_hit[g]  = pif.edge_hit;
      assign level_hit[g] = pif.level_hit;
      gdt_pin_det u_det
      (
        .clk   (SYS_CLK),
        .rst_n (RESETN),
        .pin   (pif.det)
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // register access and event logic
  // ---------------------------------------------------------------
  logic [7:0]  wmask;
  logic [7:0]  wval;
  logic        wr_hit;
  logic        rd_hit;
  logic [8:0]  set_ev;
  logic [8:0]  clr_ev;
  logic [8:0]  masked;
  logic [8:0]  stat_view;
  logic [8:0]  combined;
  logic [2:0]  dsel;
  logic [2:0]  tsel;
  logic [31:0] rd;

  always_comb
  begin
    st_next   = st_reg;
    wmask     = AVS_WRITEDATA[gdt_pkg::MASK_LSB +: 8];
    wval      = AVS_WRITEDATA[gdt_pkg::VALUE_LSB +: 8];
    // ---------------------------------------------------------------
    // bus handshake
    // ---------------------------------------------------------------
    // one wait state: a read samples the state at the taking edge, while a write
    // lands at the answer edge, where the master still holds every qualifier
    wr_hit    = AVS_WRITE & st_reg.acked;
    rd_hit    = AVS_READ & ~st_reg.acked;
    clr_ev    = 9'h000;
    // the peripheral sees the synchronised level, never the raw pad
    pad_gated = level & st_reg.pad_en;
    dsel      = st_reg.sel_dir[2:0];
    tsel      = st_reg.sel_type[2:0];
    rd        = 32'h00000000;

    st_next.acked   = (AVS_READ | AVS_WRITE) & ~st_reg.acked;
    st_next.waitreq = ~st_next.acked;

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    // partial writes are answered but dropped: every field here wants a full word
    if (wr_hit && AVS_BYTEENABLE == 4'hF)
    begin
      case (AVS_ADDRESS)
        gdt_pkg::DIR_SET_OFS:
        begin
          for (int i = 0; i < N; i++)
          begin
            if (wmask[i])
            begin
              st_next.dir[i] = wval[1:0];
            end
          end
          // the pin select rides along with every direction write
          st_next.sel_dir = AVS_WRITEDATA[gdt_pkg::SEL_LSB +: 8];
        end
        gdt_pkg::PAD_EN_OFS:
        begin
          st_next.pad_en = (st_reg.pad_en & ~wmask) | (wval & wmask);
        end
        gdt_pkg::DMA_SET_OFS:
        begin
          st_next.dma_en = st_reg.dma_en | wmask;
        end
        gdt_pkg::DMA_CLR_OFS:
        begin
          st_next.dma_en = st_reg.dma_en & ~wmask;
        end
        gdt_pkg::INT_EN_OFS:
        begin
          st_next.int_en = st_reg.int_en | AVS_WRITEDATA[8:0];
        end
        gdt_pkg::INT_DIS_OFS:
        begin
          st_next.int_en = st_reg.int_en & ~AVS_WRITEDATA[8:0];
        end
        gdt_pkg::INT_STAT_OFS:
        begin
          st_next.view = AVS_WRITEDATA[gdt_pkg::VIEW_BIT];
        end
        gdt_pkg::INT_CLR_OFS:
        begin
          clr_ev = AVS_WRITEDATA[8:0];
        end
        gdt_pkg::TYPE_SET_OFS:
        begin
          for (int i = 0; i < N; i++)
          begin
            if (wmask[i])
            begin
              st_next.sense[i]    = wval[2:0];
              st_next.discrete[i] = wval[gdt_pkg::DISC_BIT];
            end
          end
          // as for direction, the select is replaced on every type write
          st_next.sel_type = AVS_WRITEDATA[gdt_pkg::SEL_LSB +: 8];
        end
        gdt_pkg::DATA_OUT_OFS:
        begin
          st_next.data_out = (st_reg.data_out & ~wmask) | (wval & wmask);
        end
        default:
        begin
          st_next.view = st_reg.view;
        end
      endcase
    end

    // ---------------------------------------------------------------
    // event flags
    // ---------------------------------------------------------------
    // edge hits stick; level hits are re-evaluated every cycle
    // level flags ignore a clear: they drop only when the pin leaves its sense
    set_ev = {DMA_DONE, edge_hit};
    for (int i = 0; i < N; i++)
    begin
      if (st_reg.sense[i] == gdt_pkg::SENSE_LOW || st_reg.sense[i] == gdt_pkg::SENSE_HIGH)
      begin
        st_next.raw[i] = level_hit[i];
      end
      else
      begin
        st_next.raw[i] = set_ev[i] | (st_reg.raw[i] & ~clr_ev[i]);
      end
    end
    st_next.raw[8] = set_ev[8] | (st_reg.raw[8] & ~clr_ev[8]);

    masked = st_reg.raw & st_reg.int_en;

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    // the view bit sticks, so software picks it once and reads many times
    stat_view = st_reg.raw;
    if (st_reg.view)
    begin
      stat_view = masked;
    end

    case (AVS_ADDRESS)
      gdt_pkg::DIR_SET_OFS:  rd = {16'h0000, st_reg.sel_dir, 8'h00};
      gdt_pkg::DIR_GET_OFS:  rd = {30'h0, st_reg.dir[dsel]};
      gdt_pkg::PAD_EN_OFS:   rd = {24'h000000, st_reg.pad_en};
      gdt_pkg::DMA_SET_OFS:  rd = {24'h000000, st_reg.dma_en};
      gdt_pkg::INT_EN_OFS:   rd = {23'h0, st_reg.int_en};
      gdt_pkg::INT_STAT_OFS: rd = {st_reg.view, 22'h0, stat_view};
      gdt_pkg::TYPE_GET_OFS: rd = {28'h0000000, st_reg.discrete[tsel], st_reg.sense[tsel]};
      gdt_pkg::DATA_OUT_OFS: rd = {24'h000000, st_reg.data_out};
      gdt_pkg::PIN_IN_OFS:   rd = {24'h000000, level};
      gdt_pkg::DMA_ACT_OFS:  rd = {24'h000000, st_reg.dma_req};
      default:               rd = 32'h00000000;
    endcase
    st_next.rdata = rd_hit ? rd : st_reg.rdata;

    // ---------------------------------------------------------------
    // pad steering per direction
    // ---------------------------------------------------------------
    for (int i = 0; i < N; i++)
    begin
      case (st_reg.dir[i])
        gdt_pkg::DIR_OUT:
        begin
          st_next.pad_out[i] = st_reg.data_out[i];
          st_next.pad_oe[i]  = st_reg.pad_en[i];
        end
        gdt_pkg::DIR_HW:
        begin
          st_next.pad_out[i] = HW_OUT[i];
          st_next.pad_oe[i]  = HW_OE[i] & st_reg.pad_en[i];
        end
        // inputs and unused codes leave the pad undriven
        default:
        begin
          st_next.pad_out[i] = 1'b0;
          st_next.pad_oe[i]  = 1'b0;
        end
      endcase
      st_next.hw_in[i] = (st_reg.dir[i] == gdt_pkg::DIR_HW) & pad_gated[i];
    end

    // ---------------------------------------------------------------
    // dma trigger and interrupt lines
    // ---------------------------------------------------------------
    // trigger and interrupt run in parallel from the same hit
    st_next.dma_req  = st_reg.dma_en & (edge_hit | level_hit);
    // discrete pins leave the combined output and use their own line;
    // the dma source has no pin of its own, so it always stays combined
    combined         = masked & {1'b1, ~st_reg.discrete};
    st_next.port_irq = |combined;
    st_next.pin_irq  = masked[7:0] & st_reg.discrete;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_reg <= ST_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign AVS_READDATA    = st_reg.rdata;
  assign AVS_WAITREQUEST = st_reg.waitreq;
  assign PAD_OUT         = st_reg.pad_out;
  assign PAD_OE          = st_reg.pad_oe;
  assign HW_IN           = st_reg.hw_in;
  assign DMA_REQ         = st_reg.dma_req;
  assign PORT_IRQ        = st_reg.port_irq;
  assign PIN_IRQ         = st_reg.pin_irq;

endmodule : gdt_port

/* File: tb/gdt_dma_model.sv */
// dma engine stand-in: one done pulse LAT cycles after the last trigger; triggers closer together share one pulse
// assumes triggers arrive on the port clock
`timescale 1ns/1ps
module gdt_dma_model
#(
  parameter int LAT = 3
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] dma_req,
  output logic            dma_done
);
  int cnt;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt      <= 0;
      dma_done <= 1'b0;
    end
    else
    begin
      cnt      <= (dma_req != 8'h00) ? LAT : ((cnt > 0) ? cnt - 1 : 0);
      dma_done <= (cnt == 1);
    end
endmodule : gdt_dma_model

/* File: tb/gdt_port_checker.sv */
// port-level assertions for the gpio port block
// assumes it is bound to gdt_port and sees only its pins
`timescale 1ns/1ps
module gdt_port_checker
(
  input wire logic        SYS_CLK,
  input wire logic        RESETN,
  input wire logic [5:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [7:0]  PAD_IN,
  input wire logic [7:0]  PAD_OUT,
  input wire logic [7:0]  PAD_OE,
  input wire logic [7:0]  HW_OUT,
  input wire logic [7:0]  HW_OE,
  input wire logic [7:0]  HW_IN,
  input wire logic        DMA_DONE,
  input wire logic [7:0]  DMA_REQ,
  input wire logic        PORT_IRQ,
  input wire logic [7:0]  PIN_IRQ
);
  logic en_reg, disc_reg, pad_reg, dma_reg, dma_was_reg, en8_reg;
  logic wr_ok;
  // tracked at the answer edge, the same edge at which the design takes a write
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && (AVS_BYTEENABLE == 4'hF);
  always_ff @(posedge SYS_CLK or negedge RESETN)
    if (!RESETN)
    begin
      {en_reg, disc_reg, pad_reg, dma_reg, dma_was_reg, en8_reg} <= 6'h00;
    end
    else
    begin
      dma_was_reg <= dma_reg;
      if (wr_ok && AVS_ADDRESS == gdt_pkg::INT_EN_OFS) en_reg <= 1'b1;
      if (wr_ok && AVS_ADDRESS == gdt_pkg::TYPE_SET_OFS && AVS_WRITEDATA[11]) disc_reg <= 1'b1;
      if (wr_ok && AVS_ADDRESS == gdt_pkg::PAD_EN_OFS) pad_reg <= 1'b1;
      if (wr_ok && AVS_ADDRESS == gdt_pkg::DMA_SET_OFS) dma_reg <= 1'b1;
      if (wr_ok && AVS_ADDRESS == gdt_pkg::DMA_CLR_OFS && AVS_WRITEDATA[7:0] == 8'hFF) dma_reg <= 1'b0;
      if (wr_ok && AVS_ADDRESS == gdt_pkg::INT_EN_OFS && AVS_WRITEDATA[8]) en8_reg <= 1'b1;
      if (wr_ok && AVS_ADDRESS == gdt_pkg::INT_DIS_OFS && AVS_WRITEDATA[8]) en8_reg <= 1'b0;
    end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  property p_wait_ans; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[1:2] !AVS_WAITREQUEST; endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no answer to request");
  property p_wait_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_irq_quiet; !en_reg |-> !PORT_IRQ && PIN_IRQ == 8'h00; endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq with nothing enabled");
  property p_disc_quiet; !disc_reg |-> PIN_IRQ == 8'h00; endproperty
  a_disc_quiet: assert property (p_disc_quiet) else $error("pin irq without discrete");
  property p_pad_gate; !pad_reg |-> PAD_OE == 8'h00 && HW_IN == 8'h00; endproperty
  a_pad_gate: assert property (p_pad_gate) else $error("pad passes while disabled");
  property p_dma_off; !dma_reg && !dma_was_reg |-> DMA_REQ == 8'h00; endproperty
  a_dma_off: assert property (p_dma_off) else $error("trigger while disabled");
  property p_dma_irq; DMA_DONE && en8_reg |-> ##[1:3] PORT_IRQ; endproperty
  a_dma_irq: assert property (p_dma_irq) else $error("dma source lost");
  property p_sync;
    (!AVS_WRITE && $stable(PAD_IN))[*6] ##1 (!AVS_WRITE && $changed(PAD_IN)) |=> (!$rose(|DMA_REQ))[*2];
  endproperty
  a_sync: assert property (p_sync) else $error("pad reached logic too early");
  c_irq: cover property ($rose(PORT_IRQ));
  c_pin: cover property ($rose(PIN_IRQ[2]));
  c_dma: cover property ($rose(DMA_DONE));
endmodule : gdt_port_checker

/* File: tb/tb.sv */
// self-checking bench for the gpio port block
// assumes gdt_port, gdt_dma_model and the checker are compiled first
`timescale 1ns/1ps
module tb;
  logic        SYS_CLK = 1'b0;
  logic        RESETN  = 1'b0;
  logic [5:0]  adr     = 6'h00;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wdat    = 32'h0;
  logic [7:0]  pad     = 8'h00;
  logic [7:0]  hw_out  = 8'h00;
  logic [7:0]  hw_oe   = 8'h00;
  logic [31:0] rdat, v;
  logic        wreq, dma_done, port_irq;
  logic [7:0]  pad_out, pad_oe, hw_in, dma_req, pin_irq;
  int          err_count = 0;
  int          checked   = 0;
  int          req_cnt   = 0;
  always #5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) if (dma_req[2] === 1'b1) req_cnt <= req_cnt + 1;
  gdt_port u_gdt_port (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .PAD_IN(pad), .PAD_OUT(pad_out), .PAD_OE(pad_oe), .HW_OUT(hw_out),
    .HW_OE(hw_oe), .HW_IN(hw_in), .DMA_DONE(dma_done), .DMA_REQ(dma_req), .PORT_IRQ(port_irq),
    .PIN_IRQ(pin_irq));
  gdt_dma_model u_gdt_dma_model (.clk(SYS_CLK), .rst_n(RESETN), .dma_req(dma_req), .dma_done(dma_done));
  task automatic final_report;
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : wait_cyc
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    adr  <= a;
    wdat <= d;
    wr   <= w;
    rd   <= !w;
    do
    begin
      @(posedge SYS_CLK);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    v = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50)
    begin
      err_count++;
      final_report();
    end
  endtask : bus
  task automatic t_reset;
    check("wait idle", 32'(wreq), 32'h1);
    bus(1'b0, gdt_pkg::DIR_GET_OFS, 32'h0);
    check("dir reset", 32'(v[1:0]), 32'(gdt_pkg::DIR_RESET));
    bus(1'b0, gdt_pkg::TYPE_GET_OFS, 32'h0);
    check("type reset", 32'(v[3:0]), 32'(gdt_pkg::SENSE_RESET));
    bus(1'b0, gdt_pkg::INT_STAT_OFS, 32'h0);
    check("stat reset", 32'(v[8:0]), 32'(gdt_pkg::FLAG_RESET));
    bus(1'b0, 6'h3C, 32'h0);
    check("unmapped", v, 32'h0);
  endtask : t_reset
  task automatic t_dir;
    bus(1'b1, gdt_pkg::DIR_SET_OFS, 32'h0000_0109);
    bus(1'b1, gdt_pkg::DIR_SET_OFS, 32'h0000_0202);
    for (int p = 0; p < 8; p++)
    begin
      bus(1'b1, gdt_pkg::DIR_SET_OFS, {8'h00, 8'(p), 16'h0000});
      bus(1'b0, gdt_pkg::DIR_GET_OFS, 32'h0);
      check("dir", 32'(v[1:0]), 32'((p == 0 || p == 3) ? gdt_pkg::DIR_OUT :
        ((p == 1) ? gdt_pkg::DIR_HW : gdt_pkg::DIR_IN)));
    end
    check("oe no pad", 32'(pad_oe), 32'h0);
    hw_oe  <= 8'h02;
    hw_out <= 8'h02;
    bus(1'b1, gdt_pkg::DATA_OUT_OFS, 32'h0000_0101);
    bus(1'b1, gdt_pkg::PAD_EN_OFS, 32'h0000_0B0B);
    pad <= 8'h02;
    wait_cyc(6);
    check("oe", 32'(pad_oe), 32'h0B);
    check("drive", 32'(pad_out & pad_oe), 32'h03);
    check("hw in", 32'(hw_in), 32'h02);
    bus(1'b0, gdt_pkg::PIN_IN_OFS, 32'h0);
    check("pin in", v, 32'h02);
    pad <= 8'h00;
    wait_cyc(6);
  endtask : t_dir
  task automatic t_sense;
    logic [4:0] up, dn;
    up = 5'b10110;
    dn = 5'b01101;
    for (int s = 0; s < 5; s++)
    begin
      bus(1'b1, gdt_pkg::TYPE_SET_OFS, {16'h0002, 5'h00, 3'(s), 8'h04});
      for (int e = 0; e < 2; e++)
      begin
        bus(1'b1, gdt_pkg::INT_CLR_OFS, 32'h0000_0004);
        pad[2] <= (e == 0);
        wait_cyc(6);
        bus(1'b0, gdt_pkg::INT_STAT_OFS, 32'h0);
        check("sense", 32'(v[2]), 32'((e == 0) ? up[s] : dn[s]));
      end
    end
  endtask : t_sense
  task automatic t_irq;
    int n0;
    bus(1'b1, gdt_pkg::TYPE_SET_OFS, 32'h0002_0104);
    bus(1'b1, gdt_pkg::DMA_SET_OFS, 32'h0000_000C);
    bus(1'b1, gdt_pkg::INT_EN_OFS, 32'h0000_0104);
    bus(1'b1, gdt_pkg::INT_CLR_OFS, 32'h0000_01FF);
    n0 = req_cnt;
    pad <= 8'h04;
    wait_cyc(14);
    check("trig", 32'(req_cnt - n0), 32'h1);
    bus(1'b0, gdt_pkg::INT_STAT_OFS, 32'h0);
    check("raw", 32'(v[8:0]), 32'h104);
    check("irq", 32'(port_irq), 32'h1);
    bus(1'b1, gdt_pkg::INT_STAT_OFS, 32'h8000_0000);
    bus(1'b1, gdt_pkg::INT_DIS_OFS, 32'h0000_0100);
    bus(1'b0, gdt_pkg::INT_STAT_OFS, 32'h0);
    check("masked", v, 32'h8000_0004);
    bus(1'b1, gdt_pkg::INT_CLR_OFS, 32'h0000_0004);
    bus(1'b1, gdt_pkg::INT_STAT_OFS, 32'h0);
    wait_cyc(2);
    check("irq off", 32'(port_irq), 32'h0);
    bus(1'b0, gdt_pkg::INT_STAT_OFS, 32'h0);
    check("cleared", 32'(v[8:0]), 32'h100);
    bus(1'b1, gdt_pkg::DMA_CLR_OFS, 32'h0000_0004);
    bus(1'b0, gdt_pkg::DMA_SET_OFS, 32'h0);
    check("dma keep", v, 32'h08);
    n0 = req_cnt;
    pad <= 8'h00;
    wait_cyc(8);
    pad <= 8'h04;
    wait_cyc(10);
    check("no trig", 32'(req_cnt - n0), 32'h0);
    bus(1'b1, gdt_pkg::TYPE_SET_OFS, 32'h0002_0904);
    bus(1'b0, gdt_pkg::TYPE_GET_OFS, 32'h0);
    check("type", 32'(v[3:0]), 32'h9);
    bus(1'b1, gdt_pkg::INT_CLR_OFS, 32'h0000_01FF);
    pad <= 8'h00;
    wait_cyc(8);
    pad <= 8'h04;
    wait_cyc(8);
    check("discrete", {23'h0, port_irq, pin_irq}, 32'h004);
  endtask : t_irq
  initial
  begin
    repeat (12) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    t_reset();
    t_dir();
    t_sense();
    t_irq();
    RESETN <= 1'b0;
    wait_cyc(2);
    RESETN <= 1'b1;
    t_reset();
    final_report();
  end
endmodule : tb
bind gdt_port gdt_port_checker u_gdt_port_checker (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .HW_OUT(HW_OUT), .HW_OE(HW_OE), .HW_IN(HW_IN),
  .DMA_DONE(DMA_DONE), .DMA_REQ(DMA_REQ), .PORT_IRQ(PORT_IRQ), .PIN_IRQ(PIN_IRQ));
